// ### rtl/suer_pkg.sv
`default_nettype none
package suer_pkg;
  // Event codes
  localparam logic [31:0] EV_NONE          = 32'h0000_0000;
  localparam logic [31:0] EV_UNIT_RESET    = 32'h0000_0001;
  localparam logic [31:0] EV_ASYNC_NOTICE  = 32'h0000_0002;
  localparam logic [31:0] EV_PARAM_CHANGE  = 32'h0000_0003;
  localparam logic [31:0] EVENTS_LOST_FLAG = 32'h8000_0000;
  // Reset reasons
  localparam logic [31:0] REASON_PRESENT   = 32'h0000_0000;
  localparam logic [31:0] REASON_APPEARED  = 32'h0000_0001;
  localparam logic [31:0] REASON_GONE      = 32'h0000_0002;
  // Sense data
  localparam logic [3:0]  SK_ILLEGAL_REQ   = 4'h5;
  localparam logic [3:0]  SK_UNIT_ATTN     = 4'h6;
  localparam logic [7:0]  ASC_GONE         = 8'h25;
  localparam logic [7:0]  ASCQ_GONE        = 8'h00;
  localparam logic [7:0]  ASC_RESET        = 8'h29;
  localparam logic [7:0]  ASCQ_RESET       = 8'h00;
  localparam logic [7:0]  ASC_APPEARED     = 8'h3F;
  localparam logic [7:0]  ASCQ_APPEARED    = 8'h0E;
  localparam logic [4:0]  INQ_TYPE_OPTICAL = 5'h05;
  // Record layout: 4 + 8 + 4 bytes
  localparam int          REC_BYTES        = 16;
  localparam int          PACE_LEN         = 4;
  // Registers (word addresses are byte offsets)
  localparam logic [7:0]  REG_CTRL         = 8'h00;
  localparam logic [7:0]  REG_STATUS       = 8'h04;
  localparam logic [7:0]  REG_SUBSCR       = 8'h08;
  localparam logic [7:0]  REG_DROPS        = 8'h0C;
  localparam logic [7:0]  REG_SENSE        = 8'h10;
  localparam int          CTRL_HOTPLUG     = 0;
  localparam int          CTRL_PACE        = 1;
  localparam int          CTRL_LOST_NOTE   = 2;
  localparam logic [2:0]  CTRL_RST         = 3'h5;

  typedef enum logic [1:0] {SUER_K_RESET, SUER_K_ASYNC, SUER_K_PARAM} suer_kind_t;
  typedef enum logic [1:0] {SUER_R_PRESENT, SUER_R_APPEARED, SUER_R_GONE} suer_why_t;

  typedef struct packed {
    suer_kind_t  kind;
    suer_why_t   why;
    logic [63:0] unit;
    logic [31:0] detail;
    logic [4:0]  inq_type;
  } suer_evt_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] length;
  } suer_buf_t;

  typedef struct packed {
    logic         valid;
    logic         short_buf;
    logic [127:0] bytes;
  } suer_rec_t;

  typedef struct packed {
    logic        valid;
    logic [63:0] unit;
    logic [3:0]  key;
    logic [7:0]  asc;
    logic [7:0]  ascq;
  } suer_sense_t;
endpackage : suer_pkg
`default_nettype wire

// ### rtl/suer_event_reporter.sv
// Functional notes
// - With no posted buffer, incoming events are dropped, never stored.
// - Optional pacing stalls event source while buffers are missing.
// - Record is LE32 code, 8-byte unit address, LE32 reason.
// - After losses, next delivered record carries bit 31 set.
// - Too-short buffer consumed at once with empty-event code 0.
// - After losses, a new buffer may get an empty record with lost bit.
// - Unit reset/appear/remove use code 1, unit field filled.
// - Reason 0 for reset-but-present, 1 for appeared.
// - Removal reason used when unit can no longer accept commands.
// - Removal and appearance sent only with hot-attach negotiated.
// - Unit 0 removal/appearance may cover whole target; driver rescans.
// - Unit events also mirrored as sense key, asc and ascq.
// - Async notice uses code 2, reason masked by subscriptions.
// - Parameter change uses code 3, asc low byte, ascq next, plus attention.
// - Parameter change never reported for inquiry type 5 units.
// - Legacy mode lays fields out in guest native byte order.
//
// Local design decisions: register access over Wishbone and the register offsets.
`default_nettype none
module suer_event_reporter (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Event source
  input  wire suer_pkg::suer_evt_t evt_i,
  input  wire logic               evt_valid_i,
  output logic                    evt_ready_o,
  // Driver buffer posted on the event queue
  input  wire suer_pkg::suer_buf_t buf_i,
  output logic                    buf_take_o,
  // Completed record written into the buffer
  output suer_pkg::suer_rec_t     rec_o,
  // Sense mirror of unit events
  output suer_pkg::suer_sense_t   sense_o,
  // Legacy byte order (guest big-endian when set)
  input  wire logic               legacy_be_i,
  // Wishbone classic slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic [31:0]             wb_dat_o,
  output logic                    wb_ack_o
);

  typedef struct packed {
    // Control and subscription
    logic                  hotplug;
    logic                  pace;
    logic                  lost_note;
    logic [31:0]           subscr;
    // Loss tracking and counters
    logic                  lost;
    logic [15:0]           drops;
    logic [31:0]           delivered;
    // Outputs towards the driver
    suer_pkg::suer_rec_t   rec;
    suer_pkg::suer_sense_t sense;
    // Bus answer
    logic                  ack;
    logic [31:0]           rdata;
  } suer_state_t;

  suer_state_t st_r;
  suer_state_t st_nxt;

  // Byte-order swap for one 32-bit word
  function automatic logic [31:0] suer_order(input logic [31:0] w, input logic be);
    logic [31:0] s;
    s = {w[7:0], w[15:8], w[23:16], w[31:24]};
    return be ? s : w;
  endfunction : suer_order

  // Pack code, unit, reason into record bytes, byte 0 in bits 7:0
  function automatic logic [127:0] suer_pack(input logic [31:0] code,
                                            input logic [63:0] unit,
                                            input logic [31:0] why,
                                            input logic        be);
    logic [31:0] c;
    logic [31:0] r;
    c = suer_order(code, be);
    r = suer_order(why, be);
    return {r, unit, c};
  endfunction : suer_pack

  // Saturating drop count, so a flood never wraps to a small number
  function automatic logic [15:0] suer_sat_inc(input logic [15:0] n);
    return (n == 16'hFFFF) ? n : n + 16'h1;
  endfunction : suer_sat_inc

  logic        wb_req;
  logic        buf_ok;
  logic        is_short;
  logic        evt_legal;
  logic        evt_fire;
  logic        evt_take;
  logic [31:0] code;
  logic [31:0] reason;
  logic [31:0] lost_bit;

  assign wb_req   = wb_cyc_i && wb_stb_i && !st_r.ack;
  assign buf_ok   = buf_i.valid;
  assign is_short = buf_i.length < 32'(suer_pkg::REC_BYTES);
  // Loss mark rides on the next record of any kind
  assign lost_bit = st_r.lost ? suer_pkg::EVENTS_LOST_FLAG : suer_pkg::EV_NONE;

  // Hot-attach gate and optical filter
  // Illegal events are taken but leave no record and no loss mark
  always_comb
  begin
    evt_legal = 1'b1;
    if (evt_i.kind == suer_pkg::SUER_K_RESET && evt_i.why != suer_pkg::SUER_R_PRESENT
        && !st_r.hotplug)
      evt_legal = 1'b0;
    if (evt_i.kind == suer_pkg::SUER_K_PARAM && evt_i.inq_type == suer_pkg::INQ_TYPE_OPTICAL)
      evt_legal = 1'b0;
  end

  // Code and reason of the current event
  always_comb
  begin
    code   = suer_pkg::EV_UNIT_RESET;
    reason = suer_pkg::REASON_PRESENT;
    unique case (evt_i.kind)
      suer_pkg::SUER_K_RESET:
      begin
        unique case (evt_i.why)
          suer_pkg::SUER_R_APPEARED: reason = suer_pkg::REASON_APPEARED;
          suer_pkg::SUER_R_GONE:     reason = suer_pkg::REASON_GONE;
          default:                   reason = suer_pkg::REASON_PRESENT;
        endcase
      end
      suer_pkg::SUER_K_ASYNC:
      begin
        code   = suer_pkg::EV_ASYNC_NOTICE;
        // Unsubscribed async bits never reach the driver
        reason = evt_i.detail & st_r.subscr;
      end
      suer_pkg::SUER_K_PARAM:
      begin
        code   = suer_pkg::EV_PARAM_CHANGE;
        reason = {16'h0000, evt_i.detail[15:0]};
      end
      default:
      begin
        code   = suer_pkg::EV_UNIT_RESET;
        reason = suer_pkg::REASON_PRESENT;
      end
    endcase
  end

  // Source held back only when pacing and no buffer
  assign evt_ready_o = buf_ok || !st_r.pace || !evt_legal;
  assign evt_fire    = evt_valid_i && evt_ready_o;
  assign evt_take    = evt_fire && evt_legal;

  always_comb
  begin
    st_nxt           = st_r;
    st_nxt.ack       = wb_req;
    st_nxt.rec.valid = 1'b0;
    st_nxt.sense.valid = 1'b0;
    buf_take_o       = 1'b0;

    if (buf_ok && is_short)
    begin
      // Short buffer eaten at once with an empty record
      buf_take_o           = 1'b1;
      st_nxt.rec.valid     = 1'b1;
      st_nxt.rec.short_buf = 1'b1;
      st_nxt.rec.bytes     = suer_pack(suer_pkg::EV_NONE | lost_bit, 64'h0,
                                       32'h0, legacy_be_i);
      // A legal event offered now finds no usable buffer and is lost
      st_nxt.lost          = evt_take;
      if (evt_take)
        st_nxt.drops = suer_sat_inc(st_r.drops);
      st_nxt.delivered     = st_r.delivered + 32'h1;
    end
    // Normal delivery, or a counted drop when no buffer is posted
    else if (evt_take)
    begin
      if (buf_ok)
      begin
        buf_take_o           = 1'b1;
        st_nxt.rec.valid     = 1'b1;
        st_nxt.rec.short_buf = 1'b0;
        st_nxt.rec.bytes     = suer_pack(code | lost_bit, evt_i.unit, reason,
                                         legacy_be_i);
        st_nxt.lost          = 1'b0;
        st_nxt.delivered     = st_r.delivered + 32'h1;
      end
      else
      begin
        // No buffer: drop, remember the loss
        st_nxt.lost  = 1'b1;
        st_nxt.drops = suer_sat_inc(st_r.drops);
      end
    end
    // Empty record with the loss mark once a buffer comes back
    else if (buf_ok && st_r.lost && st_r.lost_note)
    begin
      buf_take_o           = 1'b1;
      st_nxt.rec.valid     = 1'b1;
      st_nxt.rec.short_buf = 1'b0;
      st_nxt.rec.bytes     = suer_pack(suer_pkg::EV_NONE | suer_pkg::EVENTS_LOST_FLAG,
                                       64'h0, 32'h0, legacy_be_i);
      st_nxt.lost          = 1'b0;
      st_nxt.delivered     = st_r.delivered + 32'h1;
    end

    // Sense mirror, independent of buffer availability
    if (evt_take && evt_i.kind != suer_pkg::SUER_K_ASYNC)
    begin
      st_nxt.sense.valid = 1'b1;
      st_nxt.sense.unit  = evt_i.unit;
      st_nxt.sense.key   = suer_pkg::SK_UNIT_ATTN;
      if (evt_i.kind == suer_pkg::SUER_K_PARAM)
      begin
        st_nxt.sense.asc  = evt_i.detail[7:0];
        st_nxt.sense.ascq = evt_i.detail[15:8];
      end
      else
      begin
        unique case (evt_i.why)
          suer_pkg::SUER_R_GONE:
          begin
            st_nxt.sense.key  = suer_pkg::SK_ILLEGAL_REQ;
            st_nxt.sense.asc  = suer_pkg::ASC_GONE;
            st_nxt.sense.ascq = suer_pkg::ASCQ_GONE;
          end
          suer_pkg::SUER_R_APPEARED:
          begin
            st_nxt.sense.asc  = suer_pkg::ASC_APPEARED;
            st_nxt.sense.ascq = suer_pkg::ASCQ_APPEARED;
          end
          default:
          begin
            st_nxt.sense.asc  = suer_pkg::ASC_RESET;
            st_nxt.sense.ascq = suer_pkg::ASCQ_RESET;
          end
        endcase
      end
    end

    // Register access
    st_nxt.rdata = 32'h0;
    // Writes land on the edge that raises ack
    if (wb_req && wb_we_i)
    begin
      unique case (wb_adr_i)
        suer_pkg::REG_CTRL:
          if (wb_sel_i[0])
          begin
            st_nxt.hotplug   = wb_dat_i[suer_pkg::CTRL_HOTPLUG];
            st_nxt.pace      = wb_dat_i[suer_pkg::CTRL_PACE];
            st_nxt.lost_note = wb_dat_i[suer_pkg::CTRL_LOST_NOTE];
          end
        suer_pkg::REG_SUBSCR:
          for (int i = 0; i < 4; i++)
            if (wb_sel_i[i])
              st_nxt.subscr[i*8 +: 8] = wb_dat_i[i*8 +: 8];
        default: ;
      endcase
    end
    // Read data stands with ack for one cycle
    else if (wb_req)
    begin
      unique case (wb_adr_i)
        suer_pkg::REG_CTRL:   st_nxt.rdata = {29'h0, st_r.lost_note, st_r.pace, st_r.hotplug};
        suer_pkg::REG_STATUS: st_nxt.rdata = {30'h0, buf_ok, st_r.lost};
        suer_pkg::REG_SUBSCR: st_nxt.rdata = st_r.subscr;
        suer_pkg::REG_DROPS:  st_nxt.rdata = {16'h0, st_r.drops};
        suer_pkg::REG_SENSE:  st_nxt.rdata = st_r.delivered;
        default:              st_nxt.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // Control bits restart at their defaults, all else cleared
      st_r           <= '0;
      st_r.hotplug   <= suer_pkg::CTRL_RST[suer_pkg::CTRL_HOTPLUG];
      st_r.pace      <= suer_pkg::CTRL_RST[suer_pkg::CTRL_PACE];
      st_r.lost_note <= suer_pkg::CTRL_RST[suer_pkg::CTRL_LOST_NOTE];
    end
    else
      st_r <= st_nxt;
  end

  assign rec_o    = st_r.rec;
  assign sense_o  = st_r.sense;
  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.rdata;

endmodule : suer_event_reporter
`default_nettype wire

// ### tb/suer_event_checker.sv
`default_nettype none
module suer_event_checker (
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire suer_pkg::suer_evt_t   evt_i,
  input wire logic                  evt_valid_i,
  input wire logic                  evt_ready_o,
  input wire suer_pkg::suer_buf_t   buf_i,
  input wire logic                  buf_take_o,
  input wire suer_pkg::suer_rec_t   rec_o,
  input wire suer_pkg::suer_sense_t sense_o,
  input wire logic                  legacy_be_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire acc = evt_valid_i && evt_ready_o;
  rec_after_take_a: assert property (buf_take_o |=> rec_o.valid)
    else $error("no record after buffer take");
  no_stray_rec_a: assert property (!buf_take_o |=> !rec_o.valid)
    else $error("record without buffer take");
  take_needs_buf_a: assert property (buf_take_o |-> buf_i.valid)
    else $error("buffer taken while none posted");
  ready_with_buf_a: assert property (buf_i.valid |-> evt_ready_o)
    else $error("event stalled with buffer posted");
  short_empty_a: assert property (
    buf_take_o && buf_i.length < 32'h10 && !legacy_be_i
    |=> rec_o.short_buf && rec_o.bytes[30:0] == 31'h0)
    else $error("short buffer without empty code");
  reset_rec_a: assert property (
    acc && buf_i.valid && buf_i.length >= 32'h10 && !legacy_be_i
    && evt_i.kind == suer_pkg::SUER_K_RESET && evt_i.why == suer_pkg::SUER_R_PRESENT
    |=> rec_o.bytes[30:0] == 31'h1 && rec_o.bytes[127:96] == 32'h0
    && rec_o.bytes[95:32] == $past(evt_i.unit))
    else $error("unit reset record wrong");
  optical_never_a: assert property (
    acc && evt_i.kind == suer_pkg::SUER_K_PARAM && evt_i.inq_type == 5'h05
    |=> !sense_o.valid && !(rec_o.valid && rec_o.bytes[30:0] == 31'h3))
    else $error("parameter change for optical unit");
  gone_sense_a: assert property (
    acc && evt_i.kind == suer_pkg::SUER_K_RESET && evt_i.why == suer_pkg::SUER_R_GONE
    |=> !sense_o.valid || {sense_o.key, sense_o.asc, sense_o.ascq} == 20'h52500)
    else $error("removal sense wrong");
  param_sense_a: assert property (
    acc && evt_i.kind == suer_pkg::SUER_K_PARAM && evt_i.inq_type != 5'h05
    |=> sense_o.valid && sense_o.key == 4'h6 && {sense_o.ascq, sense_o.asc}
    == $past(evt_i.detail[15:0]))
    else $error("parameter change sense wrong");
  cover property (rec_o.valid && rec_o.bytes[31]);
  cover property (sense_o.valid);
  cover property (acc && !buf_i.valid);
  cover property (evt_valid_i && !evt_ready_o);
endmodule : suer_event_checker
bind suer_event_reporter suer_event_checker i_chk (.clk_i(clk_i), .rst_i(rst_i),
  .evt_i(evt_i), .evt_valid_i(evt_valid_i), .evt_ready_o(evt_ready_o), .buf_i(buf_i),
  .buf_take_o(buf_take_o), .rec_o(rec_o), .sense_o(sense_o), .legacy_be_i(legacy_be_i));
`default_nettype wire

// ### tb/suer_drv_model.sv
`default_nettype none
module suer_drv_model (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              post_i,
  input wire logic [31:0]       len_i,
  input wire logic              take_i,
  output var suer_pkg::suer_buf_t buf_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0]  cnt_r;
  logic [31:0] len_r;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt_r <= 5'h00;
    else
      cnt_r <= cnt_r + 5'(post_i) - 5'(take_i);
    if (rst_i)
      len_r <= 32'h10;
    else if (post_i)
      len_r <= len_i;
  end
  assign buf_o.valid = (cnt_r != 5'h00);
  // Nothing posted: length shows garbage
  assign buf_o.length = buf_o.valid ? len_r : ~len_r;
endmodule : suer_drv_model
`default_nettype wire

// ### tb/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, evt_v, ready, take, be, post_v, cyc, stb, wwe, ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, dat, r, len;
  logic [63:0] unit;
  logic [128:0] m, got;
  logic [128:0] rq[$], mq[$];
  logic [83:0] sq[$];
  logic [19:0] st[3] = '{20'h62900, 20'h63F0E, 20'h52500};
  int err_count, total_checks;
  suer_pkg::suer_evt_t evt;
  suer_pkg::suer_buf_t bufs;
  suer_pkg::suer_rec_t rec;
  suer_pkg::suer_sense_t sn;
  suer_event_reporter i_suer_event_reporter (.clk_i(clk_i), .rst_i(rst_i), .evt_i(evt),
    .evt_valid_i(evt_v), .evt_ready_o(ready), .buf_i(bufs), .buf_take_o(take), .rec_o(rec),
    .sense_o(sn), .legacy_be_i(be), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wwe),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat), .wb_ack_o(ack));
  suer_drv_model i_suer_drv_model (.clk_i(clk_i), .rst_i(rst_i), .post_i(post_v),
    .len_i(len), .take_i(take), .buf_o(bufs));
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic lim(input int n);
    if (n >= 20)
    begin
      err_count++;
      tally_and_finish;
    end
  endtask : lim
  task automatic cmp(input logic [128:0] g, input logic [128:0] e);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {cyc, stb, wwe, adr, wdat, sel} <= {2'b11, we, a, d, 4'hF};
    for (n = 0; n < 20 && ack !== 1'b1; n++)
      @(posedge clk_i);
    lim(n);
    r = dat;
    {cyc, stb} <= 2'b00;
  endtask : wb
  task automatic post(input logic [31:0] l);
    @(posedge clk_i);
    {post_v, len} <= {1'b1, l};
    @(posedge clk_i);
    post_v <= 1'b0;
  endtask : post
  task automatic ev(input suer_pkg::suer_kind_t k, input suer_pkg::suer_why_t w,
                    input logic [31:0] det, input logic [4:0] it);
    int n;
    @(posedge clk_i);
    evt <= '{k, w, unit, det, it};
    evt_v <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk_i);
      if (ready === 1'b1)
        break;
    end
    lim(n);
    evt_v <= 1'b0;
  endtask : ev
  function automatic logic [128:0] mk(input logic [31:0] c, input logic [31:0] e);
    return {1'b0, be ? 32'({<<8{e}}) : e, unit, be ? 32'({<<8{c}}) : c};
  endfunction : mk
  always @(posedge clk_i)
  begin
    if (rec.valid === 1'b1)
    begin
      m = mq.size() ? mq.pop_front() : '1;
      got = {rec.short_buf, rec.bytes};
      cmp(got & m, rq.size() ? rq.pop_front() & m : ~got);
    end
    if (sn.valid === 1'b1)
      cmp({sn.unit, sn.key, sn.asc, sn.ascq}, sq.size() ? sq.pop_front() : '1);
  end
  initial
  begin
    {rst_i, evt_v, post_v, cyc, stb, wwe, be} = 7'h40;
    {evt, len, adr, wdat, sel, unit} = '0;
    void'($urandom(32'hD015));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h00, 32'h0);
    cmp(r, 32'h5);
    wb(1'b1, 8'h40, 32'hFFFF);
    wb(1'b0, 8'h40, 32'h0);
    cmp(r, 32'h0);
    for (int w = 0; w < 3; w++)
    begin
      be <= (w == 2);
      unit = {$urandom, $urandom};
      post(32'h10);
      rq.push_back(mk(32'h1, 32'(w)));
      sq.push_back({unit, st[w]});
      ev(suer_pkg::SUER_K_RESET, suer_pkg::suer_why_t'(w), 32'h0, 5'h00);
    end
    be <= 1'b0;
    wb(1'b1, 8'h00, 32'h4);
    post(32'h10);
    ev(suer_pkg::SUER_K_RESET, suer_pkg::SUER_R_GONE, 32'h0, 5'h00);
    ev(suer_pkg::SUER_K_RESET, suer_pkg::SUER_R_APPEARED, 32'h0, 5'h00);
    rq.push_back(mk(32'h1, 32'h0));
    sq.push_back({unit, st[0]});
    ev(suer_pkg::SUER_K_RESET, suer_pkg::SUER_R_PRESENT, 32'h0, 5'h00);
    wb(1'b1, 8'h08, 32'h12);
    rq.push_back(mk(32'h3, 32'h092A));
    sq.push_back({unit, 20'h62A09});
    post(32'h10);
    ev(suer_pkg::SUER_K_PARAM, suer_pkg::SUER_R_PRESENT, 32'h092A, 5'h00);
    ev(suer_pkg::SUER_K_PARAM, suer_pkg::SUER_R_PRESENT, 32'h092A, 5'h05);
    post(32'h10);
    rq.push_back(mk(32'h2, 32'h12));
    ev(suer_pkg::SUER_K_ASYNC, suer_pkg::SUER_R_PRESENT, 32'h3F, 5'h00);
    wb(1'b1, 8'h00, 32'h1);
    ev(suer_pkg::SUER_K_ASYNC, suer_pkg::SUER_R_PRESENT, 32'h12, 5'h00);
    wb(1'b0, 8'h0C, 32'h0);
    cmp(r, 32'h1);
    wb(1'b0, 8'h04, 32'h0);
    cmp(r, 32'h1);
    post(32'h10);
    rq.push_back(mk(32'h80000002, 32'h12));
    ev(suer_pkg::SUER_K_ASYNC, suer_pkg::SUER_R_PRESENT, 32'h12, 5'h00);
    wb(1'b1, 8'h00, 32'h5);
    ev(suer_pkg::SUER_K_ASYNC, suer_pkg::SUER_R_PRESENT, 32'h12, 5'h00);
    rq = '{{1'b0, 128'h8000_0000}, {1'b1, 128'h0}};
    mq = '{{1'b1, 128'hFFFF_FFFF}, {1'b1, 128'hFFFF_FFFF}};
    post(32'h10);
    repeat (3) @(posedge clk_i);
    post(32'h8);
    repeat (3) @(posedge clk_i);
    wb(1'b1, 8'h00, 32'h3);
    unit = {$urandom, $urandom};
    rq.push_back(mk(32'h2, 32'h12));
    fork
      ev(suer_pkg::SUER_K_ASYNC, suer_pkg::SUER_R_PRESENT, 32'h12, 5'h00);
      begin
        repeat (4) @(posedge clk_i);
        cmp(ready, 1'b0);
        post(32'h10);
      end
    join
    repeat (4) @(posedge clk_i);
    cmp(rq.size(), 0);
    wb(1'b0, 8'h10, 32'h0);
    cmp(r, 32'hA);
    wb(1'b0, 8'h04, 32'h0);
    cmp(r, 32'h0);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h0C, 32'h0);
    cmp(r, 32'h0);
    wb(1'b0, 8'h00, 32'h0);
    cmp(r, 32'h5);
    tally_and_finish;
  end
endmodule : tb_top
`default_nettype wire
